// >>> rtl/timer8_top.sv
/*
  8-bit timer/counter with normal, clear-on-match and fast PWM modes,
  two compare channels and a classic Wishbone register slave.
  Assumes a single 25 MHz sys_clk, synchronous inputs, and an interrupt
  controller outside that pulses the serviced inputs.
*/
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
// How it works
// - Normal mode counts up only, wraps 0xFF to 0x00.
// - Normal mode sets overflow flag as the count becomes zero.
// - Overflow flag clears when its interrupt is serviced.
// - Normal mode accepts a count write at any moment.
// - Clear-on-match mode returns count to zero on match with compare A.
// - Clear-on-match mode sets compare flag A at each top.
// - Clear-on-match compare A writes are direct; missed match wraps through 0xFF.
// - Clear-on-match action 0x1 toggles wave output A on each match.
// - Prescaler divides by 1, 8, 64, 256 or 1024.
// - Clear-on-match sets overflow flag on wrap from 0xFF.
// - Codes 0x3 and 0x7 select fast PWM, top 0xFF or compare A.
// - Fast PWM clears the count on the tick after reaching top.
// - Fast PWM sets overflow flag each time count wraps from top to zero.
// - Fast PWM action 0x2 clears on match, sets at bottom; 0x3 reverse.
// - Fast PWM toggle on A only with mode bit two; not on B.
// - Fast PWM with top 0xFF has a 256-tick period.
// - Compare zero gives a spike, compare max a constant level.
// - Wave output reaches the pin only when its direction is output.
// - PWM compare writes are buffered and loaded at top.
// - Count write beats any clear or count in the same cycle.
// - Match sets compare flag; write one or service clears it.
// - Clock source 0x0 stops the timer; count stays accessible.
`timescale 1ns/1ns
module timer8_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // External count source
    input wire logic ext_clk_in,
    // Interrupt service acknowledges
    input wire logic ovf_serviced,
    input wire logic cmp_a_serviced,
    input wire logic cmp_b_serviced,
    // Event flags
    output logic overflow_flag,
    output logic compare_flag_a,
    output logic compare_flag_b,
    // Wave pins
    output logic wave_out_a,
    output logic wave_a_oe_n,
    output logic wave_out_b,
    output logic wave_b_oe_n
);

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = (adr[7:2] == ofs[7:2]);
    endfunction : hit

    function automatic logic wave_next(input logic cur, input logic [1:0] act, input logic pwm,
                                       input logic match, input logic bottom, input logic can_toggle);
        logic res;
        res = cur;
        if (pwm) begin
            case (act)
                timer8_pkg::ACT_TOGGLE: res = (can_toggle && match) ? ~cur : cur;
                timer8_pkg::ACT_CLEAR: res = bottom ? 1'b1 : (match ? 1'b0 : cur);
                timer8_pkg::ACT_SET: res = bottom ? 1'b0 : (match ? 1'b1 : cur);
                default: res = cur;
            endcase
        end else if (match) begin
            case (act)
                timer8_pkg::ACT_TOGGLE: res = ~cur;
                timer8_pkg::ACT_CLEAR: res = 1'b0;
                timer8_pkg::ACT_SET: res = 1'b1;
                default: res = cur;
            endcase
        end
        wave_next = res;
    endfunction : wave_next

    timer8_pkg::ctrl_type ctrl_q, ctrl_d;
    timer8_pkg::flags_type flags_q, flags_d, flag_set, flag_clr;
    logic [7:0] cnt_q, cnt_d;
    logic [7:0] buf_a_q, buf_a_d, buf_b_q, buf_b_d;
    logic [7:0] ocr_a_q, ocr_a_d, ocr_b_q, ocr_b_d;
    logic [1:0] dir_q, dir_d;
    logic block_q, block_d;
    logic oc_a_q, oc_a_d, oc_b_q, oc_b_d;
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic pin_a_q, pin_a_d, pin_b_q, pin_b_d;
    logic oe_a_n_q, oe_a_n_d, oe_b_n_q, oe_b_n_d;

    logic tick, req, wr_fire, wr_lane, cnt_wr, is_pwm, at_top, clear_now;
    logic match_a, match_b, bottom_evt, ovf_evt;
    logic [7:0] top_val;

    timer8_prescaler u_prescaler (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .clk_sel(ctrl_q.clk_sel),
        .ext_clk_in(ext_clk_in),
        .tick(tick)
    );

    // Bus: ack one cycle after request; write lands on the ack edge
    always_comb begin
        req = wb_cyc_i & wb_stb_i;
        ack_d = req & ~ack_q;
        wr_fire = clk_en & req & wb_we_i & ack_q;
        wr_lane = wr_fire & wb_sel_i[0];
        rdat_d = rdat_q;
        if (req & ~ack_q) begin
            rdat_d = 32'h0000_0000;
            if (hit(wb_adr_i, timer8_pkg::OFS_CONTROL_A)) begin
                rdat_d[7:0] = {ctrl_q.action_a, ctrl_q.action_b, 2'h0, ctrl_q.mode[1:0]};
            end else if (hit(wb_adr_i, timer8_pkg::OFS_CONTROL_B)) begin
                rdat_d[7:0] = {4'h0, ctrl_q.mode[2], ctrl_q.clk_sel};
            end else if (hit(wb_adr_i, timer8_pkg::OFS_COUNT)) begin
                rdat_d[7:0] = cnt_q;
            end else if (hit(wb_adr_i, timer8_pkg::OFS_COMPARE_A)) begin
                rdat_d[7:0] = buf_a_q;
            end else if (hit(wb_adr_i, timer8_pkg::OFS_COMPARE_B)) begin
                rdat_d[7:0] = buf_b_q;
            end else if (hit(wb_adr_i, timer8_pkg::OFS_FLAGS)) begin
                rdat_d[7:0] = {5'h00, flags_q};
            end else if (hit(wb_adr_i, timer8_pkg::OFS_PIN_DIR)) begin
                rdat_d[7:0] = {6'h00, dir_q};
            end
        end
    end

    // Control and direction registers
    always_comb begin
        ctrl_d = ctrl_q;
        dir_d = dir_q;
        if (wr_lane && hit(wb_adr_i, timer8_pkg::OFS_CONTROL_A)) begin
            ctrl_d.action_a = wb_dat_i[timer8_pkg::CTLA_ACT_A_POS +: 2];
            ctrl_d.action_b = wb_dat_i[timer8_pkg::CTLA_ACT_B_POS +: 2];
            ctrl_d.mode[1:0] = wb_dat_i[timer8_pkg::CTLA_MODE_POS +: 2];
        end
        if (wr_lane && hit(wb_adr_i, timer8_pkg::OFS_CONTROL_B)) begin
            ctrl_d.mode[2] = wb_dat_i[timer8_pkg::CTLB_BIT2_POS];
            ctrl_d.clk_sel = wb_dat_i[timer8_pkg::CTLB_CS_POS +: 3];
        end
        if (wr_lane && hit(wb_adr_i, timer8_pkg::OFS_PIN_DIR)) begin
            dir_d = {wb_dat_i[timer8_pkg::DIR_B_POS], wb_dat_i[timer8_pkg::DIR_A_POS]};
        end
    end

    // Counter, compare and flags
    always_comb begin
        cnt_wr = wr_lane & hit(wb_adr_i, timer8_pkg::OFS_COUNT);
        is_pwm = (ctrl_q.mode == timer8_pkg::MODE_FAST_PWM_MAX) || (ctrl_q.mode == timer8_pkg::MODE_FAST_PWM_CMP);
        top_val = (ctrl_q.mode == timer8_pkg::MODE_FAST_PWM_CMP) ? ocr_a_q : timer8_pkg::COUNT_MAX;
        at_top = is_pwm && (cnt_q == top_val);
        clear_now = at_top || ((ctrl_q.mode == timer8_pkg::MODE_CLEAR_ON_MATCH) && (cnt_q == ocr_a_q));
        // Compare A below the count simply misses until the wrap
        cnt_d = cnt_q;
        block_d = block_q;
        if (cnt_wr) begin
            cnt_d = wb_dat_i[7:0];
            block_d = 1'b1;
        end else if (tick) begin
            cnt_d = clear_now ? timer8_pkg::COUNT_BOTTOM : cnt_q + 8'h01;
            block_d = 1'b0;
        end
        // A count write masks the next match so equal preloads stay silent
        match_a = tick && !block_q && (cnt_q == ocr_a_q);
        match_b = tick && !block_q && (cnt_q == ocr_b_q);
        bottom_evt = tick && !cnt_wr && at_top;
        ovf_evt = tick && !cnt_wr && (is_pwm ? at_top : (cnt_q == timer8_pkg::COUNT_MAX));
        flag_set = '{cmp_b: match_b, cmp_a: match_a, ovf: ovf_evt};
        flag_clr.ovf = ovf_serviced | (wr_lane & hit(wb_adr_i, timer8_pkg::OFS_FLAGS)
                       & wb_dat_i[timer8_pkg::FLAG_OVF_POS]);
        flag_clr.cmp_a = cmp_a_serviced | (wr_lane & hit(wb_adr_i, timer8_pkg::OFS_FLAGS)
                         & wb_dat_i[timer8_pkg::FLAG_CMP_A_POS]);
        flag_clr.cmp_b = cmp_b_serviced | (wr_lane & hit(wb_adr_i, timer8_pkg::OFS_FLAGS)
                         & wb_dat_i[timer8_pkg::FLAG_CMP_B_POS]);
        // Set wins so an event in the clearing cycle is kept
        flags_d = flag_set | (flags_q & ~flag_clr);
        buf_a_d = (wr_lane && hit(wb_adr_i, timer8_pkg::OFS_COMPARE_A)) ? wb_dat_i[7:0] : buf_a_q;
        buf_b_d = (wr_lane && hit(wb_adr_i, timer8_pkg::OFS_COMPARE_B)) ? wb_dat_i[7:0] : buf_b_q;
        if (!is_pwm) begin
            ocr_a_d = buf_a_d;
            ocr_b_d = buf_b_d;
        end else if (bottom_evt) begin
            ocr_a_d = buf_a_q;
            ocr_b_d = buf_b_q;
        end else begin
            ocr_a_d = ocr_a_q;
            ocr_b_d = ocr_b_q;
        end
    end

    // Wave generation and pin gating
    always_comb begin
        oc_a_d = oc_a_q;
        oc_b_d = oc_b_q;
        if (tick) begin
            oc_a_d = wave_next(oc_a_q, ctrl_q.action_a, is_pwm, match_a, bottom_evt, ctrl_q.mode[2]);
            oc_b_d = wave_next(oc_b_q, ctrl_q.action_b, is_pwm, match_b, bottom_evt, 1'b0);
        end
        oe_a_n_d = ~(dir_q[0] && (ctrl_q.action_a != timer8_pkg::ACT_OFF));
        oe_b_n_d = ~(dir_q[1] && (ctrl_q.action_b != timer8_pkg::ACT_OFF));
        pin_a_d = ~oe_a_n_d & oc_a_d;
        pin_b_d = ~oe_b_n_d & oc_b_d;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= '0;
            dir_q <= timer8_pkg::RST_DIR;
            cnt_q <= timer8_pkg::RST_COUNT;
            block_q <= 1'b0;
            flags_q <= '0;
            buf_a_q <= timer8_pkg::RST_COMPARE;
            buf_b_q <= timer8_pkg::RST_COMPARE;
            ocr_a_q <= timer8_pkg::RST_COMPARE;
            ocr_b_q <= timer8_pkg::RST_COMPARE;
            oc_a_q <= 1'b0;
            oc_b_q <= 1'b0;
            pin_a_q <= 1'b0;
            pin_b_q <= 1'b0;
            oe_a_n_q <= 1'b1;
            oe_b_n_q <= 1'b1;
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else if (clk_en) begin
            ctrl_q <= ctrl_d;
            dir_q <= dir_d;
            cnt_q <= cnt_d;
            block_q <= block_d;
            flags_q <= flags_d;
            buf_a_q <= buf_a_d;
            buf_b_q <= buf_b_d;
            ocr_a_q <= ocr_a_d;
            ocr_b_q <= ocr_b_d;
            oc_a_q <= oc_a_d;
            oc_b_q <= oc_b_d;
            pin_a_q <= pin_a_d;
            pin_b_q <= pin_b_d;
            oe_a_n_q <= oe_a_n_d;
            oe_b_n_q <= oe_b_n_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign overflow_flag = flags_q.ovf;
    assign compare_flag_a = flags_q.cmp_a;
    assign compare_flag_b = flags_q.cmp_b;
    assign wave_out_a = pin_a_q;
    assign wave_a_oe_n = oe_a_n_q;
    assign wave_out_b = pin_b_q;
    assign wave_b_oe_n = oe_b_n_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    property p_normal_wrap;
        tick && !cnt_wr && ctrl_q.mode == timer8_pkg::MODE_NORMAL && cnt_q == 8'hFF |=> cnt_q == 8'h00 && overflow_flag;
    endproperty
    a_normal_wrap: assert property (p_normal_wrap) else $error("normal wrap or overflow wrong");

    property p_normal_inc;
        tick && !cnt_wr && ctrl_q.mode == timer8_pkg::MODE_NORMAL && cnt_q != 8'hFF |=> cnt_q == $past(cnt_q) + 8'h01;
    endproperty
    a_normal_inc: assert property (p_normal_inc) else $error("normal count did not increment");

    property p_ovf_service;
        clk_en && ovf_serviced && !ovf_evt |=> !overflow_flag;
    endproperty
    a_ovf_service: assert property (p_ovf_service) else $error("overflow flag not cleared on service");

    property p_cnt_write;
        cnt_wr |=> cnt_q == $past(wb_dat_i[7:0]) ##1 (!compare_flag_a || $past(compare_flag_a));
    endproperty
    a_cnt_write: assert property (p_cnt_write) else $error("count write lost or match not blocked");

    property p_ctc_clear;
        tick && !cnt_wr && ctrl_q.mode == timer8_pkg::MODE_CLEAR_ON_MATCH && cnt_q == ocr_a_q && !block_q
            |=> cnt_q == 8'h00 && compare_flag_a;
    endproperty
    a_ctc_clear: assert property (p_ctc_clear) else $error("clear-on-match failed");

    property p_ctc_toggle;
        match_a && ctrl_q.mode == timer8_pkg::MODE_CLEAR_ON_MATCH && ctrl_q.action_a == timer8_pkg::ACT_TOGGLE
            |=> oc_a_q != $past(oc_a_q);
    endproperty
    a_ctc_toggle: assert property (p_ctc_toggle) else $error("wave A did not toggle");

    property p_pwm_top;
        tick && !cnt_wr && at_top |=> cnt_q == 8'h00 && overflow_flag;
    endproperty
    a_pwm_top: assert property (p_pwm_top) else $error("fast pwm top handling wrong");

    property p_pwm_bottom;
        bottom_evt && ctrl_q.action_b == timer8_pkg::ACT_CLEAR |=> oc_b_q;
    endproperty
    a_pwm_bottom: assert property (p_pwm_bottom) else $error("non-inverting pwm not set at bottom");

    property p_buffer_hold;
        is_pwm && !bottom_evt |=> ocr_a_q == $past(ocr_a_q);
    endproperty
    a_buffer_hold: assert property (p_buffer_hold) else $error("pwm compare changed off top");

    property p_stopped;
        ctrl_q.clk_sel == timer8_pkg::CS_STOP && !cnt_wr |=> cnt_q == $past(cnt_q);
    endproperty
    a_stopped: assert property (p_stopped) else $error("stopped timer moved");

    property p_pin_gate;
        clk_en && !dir_q[0] |=> wave_a_oe_n && !wave_out_a;
    endproperty
    a_pin_gate: assert property (p_pin_gate) else $error("pin driven while input");

    property p_cmp_flag;
        match_a |=> compare_flag_a;
    endproperty
    a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag A not set");

    c_normal_ovf: cover property (ovf_evt && ctrl_q.mode == timer8_pkg::MODE_NORMAL);
    c_ctc_toggle: cover property (match_a && ctrl_q.mode == timer8_pkg::MODE_CLEAR_ON_MATCH);
    c_pwm_bottom: cover property (bottom_evt && ctrl_q.mode == timer8_pkg::MODE_FAST_PWM_CMP);

endmodule : timer8_top

// >>> rtl/timer8_pkg.sv
/*
  Shared constants and types for the 8-bit timer/counter: register offsets,
  field positions, reset values, mode, action and clock source codes.
  Assumes a 32-bit classic Wishbone bus with byte addresses and 8-bit registers.
*/
package timer8_pkg;

    localparam int CNT_W = 8;
    localparam int PRE_W = 10;

    // Register byte offsets
    localparam logic [7:0] OFS_CONTROL_A = 8'h00;
    localparam logic [7:0] OFS_CONTROL_B = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_COMPARE_A = 8'h0C;
    localparam logic [7:0] OFS_COMPARE_B = 8'h10;
    localparam logic [7:0] OFS_FLAGS = 8'h14;
    localparam logic [7:0] OFS_PIN_DIR = 8'h18;

    // Field positions
    localparam int CTLA_ACT_A_POS = 6;
    localparam int CTLA_ACT_B_POS = 4;
    localparam int CTLA_MODE_POS = 0;
    localparam int CTLB_BIT2_POS = 3;
    localparam int CTLB_CS_POS = 0;
    localparam int FLAG_OVF_POS = 0;
    localparam int FLAG_CMP_A_POS = 1;
    localparam int FLAG_CMP_B_POS = 2;
    localparam int DIR_A_POS = 0;
    localparam int DIR_B_POS = 1;

    // Reset values
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_COMPARE = 8'h00;
    localparam logic [1:0] RST_DIR = 2'h0;

    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;

    // Waveform mode codes {mode_bit_two, low bits}
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_CLEAR_ON_MATCH = 3'h2;
    localparam logic [2:0] MODE_FAST_PWM_MAX = 3'h3;
    localparam logic [2:0] MODE_FAST_PWM_CMP = 3'h7;

    // Output actions
    localparam logic [1:0] ACT_OFF = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;

    // Clock source select codes
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;

    // Prescaler masks: tick when the masked low bits are all ones
    localparam logic [PRE_W-1:0] MASK_DIV1 = 10'h000;
    localparam logic [PRE_W-1:0] MASK_DIV8 = 10'h007;
    localparam logic [PRE_W-1:0] MASK_DIV64 = 10'h03F;
    localparam logic [PRE_W-1:0] MASK_DIV256 = 10'h0FF;
    localparam logic [PRE_W-1:0] MASK_DIV1024 = 10'h3FF;

    typedef struct packed {
        logic [1:0] action_a;
        logic [1:0] action_b;
        logic [2:0] mode;
        logic [2:0] clk_sel;
    } ctrl_type;

    typedef struct packed {
        logic cmp_b;
        logic cmp_a;
        logic ovf;
    } flags_type;

endpackage : timer8_pkg

// >>> rtl/timer8_prescaler.sv
/*
  Prescaler producing the timer clock enable from the I/O clock.
  Assumes ext_clk_in is already synchronous to sys_clk.
*/
`timescale 1ns/1ns
module timer8_prescaler (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // Control
    input wire logic [2:0] clk_sel,
    input wire logic ext_clk_in,
    // Timer clock enable
    output logic tick
);

    logic [timer8_pkg::PRE_W-1:0] pre_q, pre_d;
    logic ext_q, ext_d;
    logic [timer8_pkg::PRE_W-1:0] mask;
    logic div_sel;

    always_comb begin
        div_sel = 1'b1;
        mask = timer8_pkg::MASK_DIV1;
        case (clk_sel)
            timer8_pkg::CS_DIV1: mask = timer8_pkg::MASK_DIV1;
            timer8_pkg::CS_DIV8: mask = timer8_pkg::MASK_DIV8;
            timer8_pkg::CS_DIV64: mask = timer8_pkg::MASK_DIV64;
            timer8_pkg::CS_DIV256: mask = timer8_pkg::MASK_DIV256;
            timer8_pkg::CS_DIV1024: mask = timer8_pkg::MASK_DIV1024;
            default: div_sel = 1'b0;
        endcase
        pre_d = (clk_sel == timer8_pkg::CS_STOP) ? '0 : pre_q + 10'h001;
        ext_d = ext_clk_in;
        tick = 1'b0;
        if (clk_en) begin
            if (div_sel) begin
                tick = ((pre_q & mask) == mask);
            end else if (clk_sel == timer8_pkg::CS_EXT_RISE) begin
                tick = ext_clk_in & ~ext_q;
            end else if (clk_sel == timer8_pkg::CS_EXT_FALL) begin
                tick = ~ext_clk_in & ext_q;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pre_q <= '0;
            ext_q <= 1'b0;
        end else if (clk_en) begin
            pre_q <= pre_d;
            ext_q <= ext_d;
        end
    end

endmodule : timer8_prescaler

// >>> dv/tb.sv
/*
  Self-checking bench for the 8-bit timer: Wishbone register tasks and
  wave timing measured against integer expectations.
  Assumes timer8_top ports and timer8_pkg offsets and codes.
*/
`timescale 1ns/1ns
module tb;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic ext_clk_in = 1'b0;
    logic ovf_serviced = 1'b0;
    logic cmp_a_serviced = 1'b0;
    logic cmp_b_serviced = 1'b0;
    logic overflow_flag, compare_flag_a, compare_flag_b;
    logic wave_out_a, wave_a_oe_n, wave_out_b, wave_b_oe_n;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;

    timer8_top dut (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clk_in(ext_clk_in),
        .ovf_serviced(ovf_serviced), .cmp_a_serviced(cmp_a_serviced), .cmp_b_serviced(cmp_b_serviced),
        .overflow_flag(overflow_flag), .compare_flag_a(compare_flag_a), .compare_flag_b(compare_flag_b),
        .wave_out_a(wave_out_a), .wave_a_oe_n(wave_a_oe_n), .wave_out_b(wave_out_b),
        .wave_b_oe_n(wave_b_oe_n));

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    // Hang guard, well above the longest wave measurement
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            errors++;
            give_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One classic cycle; no latency assumed, only the ack
    task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= {24'h000000, d};
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(negedge sys_clk);
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    // Cycles until the chosen wave pin shows level v, capped
    task automatic wl(input logic b, input logic v, output int n);
        n = 0;
        while ((b ? wave_out_b : wave_out_a) !== v && n < 9000) begin
            @(negedge sys_clk);
            n++;
        end
    endtask : wl

    initial begin
        logic [31:0] q;
        int divs[5];
        int k, c, t, n1, n2, v;
        divs = '{1, 8, 64, 256, 1024};
        void'($urandom(32'hD5A6));
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        wb(1'b0, timer8_pkg::OFS_COUNT, 8'h00, q);
        chk("count_rst", q, 32'h0);
        wb(1'b0, 8'h1C, 8'h00, q);
        chk("unmapped", q, 32'h0);
        // Normal mode: write while stopped, run through the wrap
        wr(timer8_pkg::OFS_COUNT, 8'hF0);
        wb(1'b0, timer8_pkg::OFS_COUNT, 8'h00, q);
        chk("count_wr", q, 32'hF0);
        wr(timer8_pkg::OFS_CONTROL_B, {5'h00, timer8_pkg::CS_DIV1});
        n1 = 0;
        while (overflow_flag !== 1'b1 && n1 < 100) begin
            @(negedge sys_clk);
            n1++;
        end
        wr(timer8_pkg::OFS_CONTROL_B, 8'h00);
        wb(1'b0, timer8_pkg::OFS_COUNT, 8'h00, q);
        chk("ovf_ticks", n1 >= 12 && n1 <= 17, 1'b1);
        chk("wrapped", q < 32'h20, 1'b1);
        @(posedge sys_clk);
        ovf_serviced <= 1'b1;
        @(posedge sys_clk);
        ovf_serviced <= 1'b0;
        @(negedge sys_clk);
        chk("ovf_srv", overflow_flag, 1'b0);
        // Clear-on-match toggle at every prescaler
        for (int i = 0; i < 5; i++) begin
            k = $urandom % 4;
            wr(timer8_pkg::OFS_CONTROL_B, 8'h00);
            wr(timer8_pkg::OFS_COMPARE_A, k[7:0]);
            wr(timer8_pkg::OFS_CONTROL_A, {timer8_pkg::ACT_TOGGLE, timer8_pkg::ACT_OFF, 4'h2});
            wr(timer8_pkg::OFS_PIN_DIR, 8'h01);
            wr(timer8_pkg::OFS_COUNT, 8'h00);
            wr(timer8_pkg::OFS_CONTROL_B, {5'h00, 3'(i + 1)});
            wl(1'b0, !wave_out_a, n1);
            wl(1'b0, !wave_out_a, n1);
            chk("ctc_half", n1, divs[i] * (k + 1));
        end
        chk("cmp_a_flag", compare_flag_a, 1'b1);
        wr(timer8_pkg::OFS_CONTROL_B, 8'h00);
        wr(timer8_pkg::OFS_FLAGS, 8'h02);
        wb(1'b0, timer8_pkg::OFS_FLAGS, 8'h00, q);
        chk("cmp_a_clr", q[1], 1'b0);
        wr(timer8_pkg::OFS_PIN_DIR, 8'h00);
        // Enable register follows the direction one cycle later
        @(negedge sys_clk);
        chk("pin_off", {wave_a_oe_n, wave_out_a}, 2'b10);
        // Fast PWM with fixed top, both polarities
        c = $urandom % 255;
        wr(timer8_pkg::OFS_COMPARE_B, c[7:0]);
        wr(timer8_pkg::OFS_PIN_DIR, 8'h02);
        for (int a = 2; a < 4; a++) begin
            wr(timer8_pkg::OFS_CONTROL_A, {timer8_pkg::ACT_OFF, 2'(a), 4'h3});
            wr(timer8_pkg::OFS_CONTROL_B, {5'h00, timer8_pkg::CS_DIV1});
            v = (a == 2);
            wl(1'b1, !v, n1);
            wl(1'b1, v, n1);
            wl(1'b1, !v, n1);
            wl(1'b1, v, n2);
            chk("pwm_match", n1, c + 1);
            chk("pwm_period", n1 + n2, 256);
        end
        // Buffered max compare: constant level once loaded
        wr(timer8_pkg::OFS_COMPARE_B, 8'hFF);
        repeat (300) @(negedge sys_clk);
        wl(1'b1, !wave_out_b, n1);
        chk("pwm_max", n1, 9000);
        // Fast PWM with compare A as top, toggle on A
        t = 16 + $urandom % 185;
        wr(timer8_pkg::OFS_CONTROL_B, 8'h00);
        chk("cmp_flags", {compare_flag_b, compare_flag_a}, 2'b11);
        chk("oe_b", wave_b_oe_n, 1'b0);
        @(posedge sys_clk);
        cmp_a_serviced <= 1'b1;
        cmp_b_serviced <= 1'b1;
        @(posedge sys_clk);
        cmp_a_serviced <= 1'b0;
        cmp_b_serviced <= 1'b0;
        @(negedge sys_clk);
        chk("cmp_srv", {compare_flag_b, compare_flag_a}, 2'b00);
        wr(timer8_pkg::OFS_COMPARE_A, t[7:0]);
        wr(timer8_pkg::OFS_COMPARE_B, 8'h00);
        wr(timer8_pkg::OFS_PIN_DIR, 8'h03);
        wr(timer8_pkg::OFS_CONTROL_A, {timer8_pkg::ACT_TOGGLE, timer8_pkg::ACT_CLEAR, 4'h3});
        wr(timer8_pkg::OFS_CONTROL_B, {4'h0, 1'b1, timer8_pkg::CS_DIV1});
        wl(1'b0, !wave_out_a, n1);
        wl(1'b0, !wave_out_a, n1);
        wl(1'b0, !wave_out_a, n1);
        chk("pwm_tgl_a", n1, t + 1);
        wl(1'b1, 1'b0, n1);
        wl(1'b1, 1'b1, n1);
        wl(1'b1, 1'b0, n1);
        wl(1'b1, 1'b1, n2);
        chk("pwm_spike", n1, 1);
        chk("pwm_top_a", n1 + n2, t + 1);
        give_verdict();
    end
endmodule : tb
